// File: hw/sai_pkg.sv
package sai_pkg;
  // Register offsets on the control port.
  localparam logic [7:0] ADDR_CONV = 8'h02;
  localparam logic [7:0] ADDR_VOL = 8'h03;
  localparam logic [7:0] ADDR_SPORT = 8'h04;
  // Reset values.
  localparam logic [7:0] RST_CONV = 8'h32;
  localparam logic [7:0] RST_VOL = 8'h40;
  localparam logic [7:0] RST_SPORT = 8'h11;
  // Converter control fields.
  localparam int CONV_HV_BIT = 7;
  localparam int CONV_MUTE_BIT = 6;
  localparam int CONV_HPF_BIT = 5;
  localparam int CONV_LPM_BIT = 4;
  localparam int CONV_RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_MAX_CODE = 3'h5;
  // Serial port control fields.
  localparam int SPORT_INV_BIT = 7;
  localparam int SPORT_EDGE_BIT = 6;
  localparam int SPORT_SW_LSB = 3;
  localparam int SW_W = 3;
  localparam int SPORT_STYLE_BIT = 2;
  localparam int SPORT_FMT_BIT = 1;
  localparam int SPORT_MODE_BIT = 0;
  // Slot width codes and their bit clock counts.
  localparam logic [2:0] SW_16 = 3'h0;
  localparam logic [2:0] SW_24 = 3'h1;
  localparam logic [2:0] SW_32 = 3'h2;
  localparam logic [2:0] SW_48 = 3'h3;
  localparam logic [2:0] SW_64 = 3'h4;
  localparam logic [11:0] BITS_16 = 12'h010;
  localparam logic [11:0] BITS_24 = 12'h018;
  localparam logic [11:0] BITS_32 = 12'h020;
  localparam logic [11:0] BITS_48 = 12'h030;
  localparam logic [11:0] BITS_64 = 12'h040;
  // Volume codes, gain arithmetic and the default filter shift.
  localparam logic [7:0] VOL_MUTE = 8'hff;
  localparam int GAIN_BASE_SHIFT = 11;
  localparam int HPF_SHIFT_DEF = 10;
  // Idle detection.
  localparam logic [11:0] IDLE_ZERO_COUNT = 12'h800;
  // Timing.
  localparam int SYS_CLK_MHZ = 25;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * SYS_CLK_MHZ + 999) / 1000;
  // Serial port operating mode.
  typedef enum logic {PORT_STEREO, PORT_TDM} port_mode_t;
endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Three stage chain; the first stage feeds only the second.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change is accepted only once the second and third stages agree.
  // One process drives the whole output so no bit has a second writer.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_level <= '0;
    end else begin
      for (int b = 0; b < WIDTH; b++) begin
        if (s2_reg[b] == s3_reg[b]) begin
          o_level[b] <= s3_reg[b];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/serial_audio_input_volume.sv
`timescale 1ns/1ns
`default_nettype none
module serial_audio_input_volume #(
  parameter int HPF_SHIFT = sai_pkg::HPF_SHIFT_DEF,
  parameter int RAMP_CYCLES = sai_pkg::RAMP_STEP_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic i_BCLK,
  input wire logic i_FRAME_SYNC,
  input wire logic i_SERIAL_AUDIO_INPUT,
  input wire logic [3:0] i_ADDR_SLOT,
  input wire logic i_SAMPLE_WIDTH_16,
  input wire logic i_PIN_SLOT_SELECT,
  input wire logic [3:0] i_SLOT_INDEX,
  input wire logic i_IDLE_POWERDOWN_ENABLE,
  input wire logic i_REG_WR,
  input wire logic [7:0] i_REG_ADDR,
  input wire logic [7:0] i_REG_WDATA,
  output logic [7:0] o_REG_RDATA,
  output logic [23:0] o_SAMPLE,
  output logic o_SAMPLE_VALID,
  output logic [7:0] o_GAIN_CODE,
  output logic o_MUTED,
  output logic o_HIGHPASS_ENABLE,
  output logic o_LOW_POWER_ENABLE,
  output logic [2:0] o_RATE_RANGE_SELECT,
  output logic o_RATE_RANGE_VALID,
  output logic o_IDLE_POWERDOWN
);
  logic [7:0] conv_reg;
  logic [7:0] vol_reg;
  logic [7:0] sport_reg;
  logic [2:0] pins;
  logic bclk_prev_reg;
  logic frame_sync_prev_reg;
  logic [11:0] pos_reg;
  logic [23:0] shift_reg;
  logic [23:0] rx_data_reg;
  logic rx_valid_reg;
  logic signed [23:0] hpf_x1_reg;
  logic signed [23:0] hpf_y1_reg;
  logic signed [23:0] hpf_out_reg;
  logic hpf_valid_reg;
  logic [7:0] cur_code_reg;
  logic [15:0] ramp_cnt_reg;
  logic [11:0] zero_cnt_reg;
  logic sample_edge;
  logic frame_start;
  logic start_level;
  logic [11:0] pos;
  logic [11:0] slot_base;
  logic [11:0] word_start;
  logic [11:0] word_len;
  logic in_word;
  logic word_last;
  logic [3:0] slot;
  logic signed [23:0] hpf_y;
  logic signed [23:0] gained;
  logic signed [23:0] final_val;
  sai_pkg::port_mode_t mode;

  // Bit clock count for a slot width code; reserved codes fall back to 32.
  function automatic logic [11:0] slot_bits(input logic [2:0] code);
    case (code)
      sai_pkg::SW_16: slot_bits = sai_pkg::BITS_16;
      sai_pkg::SW_24: slot_bits = sai_pkg::BITS_24;
      sai_pkg::SW_32: slot_bits = sai_pkg::BITS_32;
      sai_pkg::SW_48: slot_bits = sai_pkg::BITS_48;
      sai_pkg::SW_64: slot_bits = sai_pkg::BITS_64;
      default: slot_bits = sai_pkg::BITS_32;
    endcase
  endfunction

  // Fractional gain for the low four code bits, steps of 0.375 dB in Q15.
  function automatic logic [15:0] gain_mant(input logic [3:0] k);
    case (k)
      4'h0: gain_mant = 16'h8000;
      4'h1: gain_mant = 16'h7a98;
      4'h2: gain_mant = 16'h756a;
      4'h3: gain_mant = 16'h7074;
      4'h4: gain_mant = 16'h6bb4;
      4'h5: gain_mant = 16'h6727;
      4'h6: gain_mant = 16'h62cb;
      4'h7: gain_mant = 16'h5e9f;
      4'h8: gain_mant = 16'h5a9f;
      4'h9: gain_mant = 16'h56cb;
      4'ha: gain_mant = 16'h5320;
      4'hb: gain_mant = 16'h4f9d;
      4'hc: gain_mant = 16'h4c40;
      4'hd: gain_mant = 16'h4907;
      4'he: gain_mant = 16'h45f1;
      default: gain_mant = 16'h42fd;
    endcase
  endfunction

  // Clamp a wide signed value into the 24-bit sample range.
  function automatic logic [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh0000_007f_ffff) begin
      sat24 = 24'h7fffff;
    end else if (v < -48'sh0000_0080_0000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  pin_sync #(.WIDTH(3)) u_pin_sync (
    .i_clk(I_SYS_CLK),
    .i_resetn(I_RESETN),
    .i_async({i_BCLK, i_FRAME_SYNC, i_SERIAL_AUDIO_INPUT}),
    .o_level(pins)
  );

  // Register writes from the control port; all eight bits are stored.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      conv_reg <= sai_pkg::RST_CONV;
      vol_reg <= sai_pkg::RST_VOL;
      sport_reg <= sai_pkg::RST_SPORT;
    end else if (i_REG_WR) begin
      if (i_REG_ADDR == sai_pkg::ADDR_CONV) conv_reg <= i_REG_WDATA;
      if (i_REG_ADDR == sai_pkg::ADDR_VOL) vol_reg <= i_REG_WDATA;
      if (i_REG_ADDR == sai_pkg::ADDR_SPORT) sport_reg <= i_REG_WDATA;
    end
  end

  // Registered read; unmapped offsets read zero.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_REG_RDATA <= 8'h00;
    end else begin
      case (i_REG_ADDR)
        sai_pkg::ADDR_CONV: o_REG_RDATA <= conv_reg;
        sai_pkg::ADDR_VOL: o_REG_RDATA <= vol_reg;
        sai_pkg::ADDR_SPORT: o_REG_RDATA <= sport_reg;
        default: o_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Static converter controls straight from the register; the gain code comes from the ramped code.
  assign o_HIGHPASS_ENABLE = conv_reg[sai_pkg::CONV_HPF_BIT];
  assign o_LOW_POWER_ENABLE = conv_reg[sai_pkg::CONV_LPM_BIT];
  assign o_RATE_RANGE_SELECT = conv_reg[sai_pkg::CONV_RATE_LSB +: sai_pkg::RATE_W];
  assign o_RATE_RANGE_VALID = (o_RATE_RANGE_SELECT <= sai_pkg::RATE_MAX_CODE);
  assign o_GAIN_CODE = cur_code_reg;

  // Frame decoding and word position within the frame.
  always_comb begin
    mode = sport_reg[sai_pkg::SPORT_MODE_BIT] ? sai_pkg::PORT_TDM : sai_pkg::PORT_STEREO;
    sample_edge = sport_reg[sai_pkg::SPORT_EDGE_BIT] ? (bclk_prev_reg & ~pins[2])
                                                     : (~bclk_prev_reg & pins[2]);
    // Stereo: left channel level per style bit; TDM pulse or 50% both rise at frame start.
    start_level = (mode == sai_pkg::PORT_TDM) ? 1'b1 : sport_reg[sai_pkg::SPORT_STYLE_BIT];
    frame_start = (pins[1] != frame_sync_prev_reg) && (pins[1] == start_level);
    pos = frame_start ? 12'h000 : pos_reg;
    slot = i_PIN_SLOT_SELECT ? i_ADDR_SLOT : i_SLOT_INDEX;
    slot_base = (mode == sai_pkg::PORT_TDM) ?
                12'(slot * slot_bits(sport_reg[sai_pkg::SPORT_SW_LSB +: sai_pkg::SW_W])) :
                12'h000;
    word_start = slot_base + (sport_reg[sai_pkg::SPORT_FMT_BIT] ? 12'h000 : 12'h001);
    word_len = i_SAMPLE_WIDTH_16 ? sai_pkg::BITS_16 : sai_pkg::BITS_24;
    in_word = (pos >= word_start) && (pos < word_start + word_len);
    word_last = (pos == word_start + word_len - 12'h001);
  end

  // Serial receive on the selected bit clock edge.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      bclk_prev_reg <= 1'b0;
      frame_sync_prev_reg <= 1'b0;
      pos_reg <= 12'hfff;
      shift_reg <= 24'h000000;
      rx_data_reg <= 24'h000000;
      rx_valid_reg <= 1'b0;
    end else begin
      bclk_prev_reg <= pins[2];
      rx_valid_reg <= 1'b0;
      if (sample_edge) begin
        frame_sync_prev_reg <= pins[1];
        pos_reg <= (pos == 12'hfff) ? pos : pos + 12'h001;
        if (in_word) shift_reg <= {shift_reg[22:0], pins[0]};
        if (word_last) begin
          rx_valid_reg <= 1'b1;
          rx_data_reg <= i_SAMPLE_WIDTH_16 ? {shift_reg[14:0], pins[0], 8'h00}
                                           : {shift_reg[22:0], pins[0]};
        end
      end
    end
  end

  // First-order DC blocker, bypassed when disabled.
  always_comb begin
    hpf_y = 24'(sat24(48'($signed(rx_data_reg)) - 48'(hpf_x1_reg) + 48'(hpf_y1_reg)
                      - 48'(hpf_y1_reg >>> HPF_SHIFT)));
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      hpf_x1_reg <= 24'sh000000;
      hpf_y1_reg <= 24'sh000000;
      hpf_out_reg <= 24'sh000000;
      hpf_valid_reg <= 1'b0;
    end else begin
      hpf_valid_reg <= rx_valid_reg;
      if (rx_valid_reg) begin
        hpf_x1_reg <= $signed(rx_data_reg);
        hpf_y1_reg <= hpf_y;
        hpf_out_reg <= o_HIGHPASS_ENABLE ? hpf_y : $signed(rx_data_reg);
      end
    end
  end

  // Volume ramp: one code step per tick toward the written code; with the hard volume bit set the written code loads at once.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      cur_code_reg <= sai_pkg::RST_VOL;
      ramp_cnt_reg <= 16'h0000;
    end else if (conv_reg[sai_pkg::CONV_HV_BIT]) begin
      cur_code_reg <= vol_reg;
      ramp_cnt_reg <= 16'h0000;
    end else if (ramp_cnt_reg == 16'(RAMP_CYCLES - 1)) begin
      ramp_cnt_reg <= 16'h0000;
      if (cur_code_reg < vol_reg) cur_code_reg <= cur_code_reg + 8'h01;
      else if (cur_code_reg > vol_reg) cur_code_reg <= cur_code_reg - 8'h01;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
    end
  end

  // Gain: mantissa from low nibble, one halving per 6 dB of high nibble.
  always_comb begin
    gained = 24'(sat24(48'(($signed(hpf_out_reg) * $signed({1'b0, gain_mant(cur_code_reg[3:0])}))
                       >>> (sai_pkg::GAIN_BASE_SHIFT + int'(cur_code_reg[7:4])))));
    o_MUTED = (cur_code_reg == sai_pkg::VOL_MUTE) | conv_reg[sai_pkg::CONV_MUTE_BIT];
    final_val = sport_reg[sai_pkg::SPORT_INV_BIT] ?
                24'(sat24(-48'(gained))) : gained;
  end

  // Output sample register.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_SAMPLE <= 24'h000000;
      o_SAMPLE_VALID <= 1'b0;
    end else begin
      o_SAMPLE_VALID <= hpf_valid_reg;
      if (hpf_valid_reg) o_SAMPLE <= o_MUTED ? 24'h000000 : final_val;
    end
  end

  // Idle detection on received samples.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      zero_cnt_reg <= 12'h000;
      o_IDLE_POWERDOWN <= 1'b0;
    end else if (!i_IDLE_POWERDOWN_ENABLE) begin
      zero_cnt_reg <= 12'h000;
      o_IDLE_POWERDOWN <= 1'b0;
    end else if (rx_valid_reg) begin
      if (rx_data_reg != 24'h000000) begin
        zero_cnt_reg <= 12'h000;
        o_IDLE_POWERDOWN <= 1'b0;
      end else if (zero_cnt_reg != sai_pkg::IDLE_ZERO_COUNT) begin
        zero_cnt_reg <= zero_cnt_reg + 12'h001;
        if (zero_cnt_reg == sai_pkg::IDLE_ZERO_COUNT - 12'h001) o_IDLE_POWERDOWN <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/sai_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sai_host_model (
  output logic o_bclk,
  output logic o_frame_sync,
  output logic o_serial_audio_input
);
  int junk = 32'h5a5a17c3;
  // The lines start quiet.
  initial begin
    o_bclk = 1'b0;
    o_frame_sync = 1'b0;
    o_serial_audio_input = 1'b0;
  end
  // One frame after one lead-in bit clock period; bit clock stands still otherwise, data shows junk outside the word and inverts after the frame.
  task automatic send(input logic [7:0] cfg, input logic [23:0] d, input int ws,
                      input int bits, input int n);
    logic st;
    st = cfg[0] | cfg[2];
    #13;
    for (int p = -1; p < n; p++) begin
      o_bclk = cfg[6];
      o_frame_sync = (p >= 0 && p < ((cfg[0] && !cfg[2]) ? 1 : n / 2)) ? st : !st;
      o_serial_audio_input = (p >= ws && p < ws + bits) ? d[23 - p + ws] : junk[p & 31];
      #160 o_bclk = !cfg[6];
      #160;
    end
    o_bclk = cfg[6];
    o_serial_audio_input = !o_serial_audio_input;
  endtask
endmodule
`default_nettype wire

// File: verif/serial_audio_input_volume_checker.sv
`timescale 1ns/1ns
`default_nettype none
module serial_audio_input_volume_checker (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic i_REG_WR,
  input wire logic [7:0] i_REG_ADDR,
  input wire logic [7:0] i_REG_WDATA,
  input wire logic [7:0] o_REG_RDATA,
  input wire logic [23:0] o_SAMPLE,
  input wire logic o_SAMPLE_VALID,
  input wire logic [7:0] o_GAIN_CODE,
  input wire logic o_MUTED,
  input wire logic o_HIGHPASS_ENABLE,
  input wire logic o_LOW_POWER_ENABLE,
  input wire logic [2:0] o_RATE_RANGE_SELECT,
  input wire logic o_RATE_RANGE_VALID
);
  logic [7:0] conv_reg;
  logic [7:0] sport_reg;
  logic conv_wr;
  // A converter control write in this cycle.
  assign conv_wr = i_REG_WR && i_REG_ADDR == sai_pkg::ADDR_CONV;
  // Shadow of the converter and serial port control registers, rebuilt from the writes.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      conv_reg <= 8'h32;
      sport_reg <= 8'h11;
    end else if (conv_wr) begin
      conv_reg <= i_REG_WDATA;
    end else if (i_REG_WR && i_REG_ADDR == sai_pkg::ADDR_SPORT) begin
      sport_reg <= i_REG_WDATA;
    end
  end
  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);
  hard_vol_a: assert property (i_REG_WR && i_REG_ADDR == sai_pkg::ADDR_VOL && conv_reg[7]
    |-> ##2 o_GAIN_CODE == $past(i_REG_WDATA, 2)) else $error("hard volume late");
  gain_step_a: assert property (!conv_reg[7] && !$past(conv_reg[7]) && $changed(o_GAIN_CODE)
    |-> o_GAIN_CODE - $past(o_GAIN_CODE) == 8'h01 || $past(o_GAIN_CODE) - o_GAIN_CODE == 8'h01)
    else $error("gain jumped");
  mute_flag_a: assert property (o_MUTED == (o_GAIN_CODE == 8'hff || conv_reg[6]))
    else $error("mute flag wrong");
  hpf_follow_a: assert property (conv_wr |=> o_HIGHPASS_ENABLE == $past(i_REG_WDATA[5]))
    else $error("filter enable wrong");
  lpm_follow_a: assert property (conv_wr |=> o_LOW_POWER_ENABLE == $past(i_REG_WDATA[4]))
    else $error("low power wrong");
  rate_range_a: assert property (o_RATE_RANGE_SELECT == conv_reg[2:0] &&
    o_RATE_RANGE_VALID == (conv_reg[2:0] <= 3'h5)) else $error("rate range wrong");
  port_read_a: assert property ($past(I_RESETN) && !$past(i_REG_WR)
    && $past(i_REG_ADDR) == sai_pkg::ADDR_SPORT |-> o_REG_RDATA == sport_reg)
    else $error("port read wrong");
  one_pulse_a: assert property (o_SAMPLE_VALID |=> !o_SAMPLE_VALID [*8])
    else $error("valid too long");
  sample_hold_a: assert property (!o_SAMPLE_VALID |-> $stable(o_SAMPLE))
    else $error("sample moved");
endmodule
bind serial_audio_input_volume serial_audio_input_volume_checker
  serial_audio_input_volume_checker_i (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN),
  .i_REG_WR(i_REG_WR), .i_REG_ADDR(i_REG_ADDR), .i_REG_WDATA(i_REG_WDATA),
  .o_REG_RDATA(o_REG_RDATA), .o_SAMPLE(o_SAMPLE), .o_SAMPLE_VALID(o_SAMPLE_VALID),
  .o_GAIN_CODE(o_GAIN_CODE), .o_MUTED(o_MUTED), .o_HIGHPASS_ENABLE(o_HIGHPASS_ENABLE),
  .o_LOW_POWER_ENABLE(o_LOW_POWER_ENABLE), .o_RATE_RANGE_SELECT(o_RATE_RANGE_SELECT),
  .o_RATE_RANGE_VALID(o_RATE_RANGE_VALID));
`default_nettype wire

// File: verif/serial_audio_input_volume_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_audio_input_volume_tb;
  logic I_SYS_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic bclk, frame_sync, serial_audio_input, valid, muted, hpf, lpm, rate_ok, idle;
  logic [3:0] addr_slot = 4'h0, slot_index = 4'h0;
  logic w16 = 1'b0, pin_sel = 1'b0, idle_en = 1'b1, reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, gain;
  logic [23:0] smp;
  logic [2:0] rate;
  logic [23:0] exp_q[$];
  int err_count = 0, comparisons = 0, seed = 32'h18ef33bb;
  // The system clock.
  always #20 I_SYS_CLK = !I_SYS_CLK;
  sai_host_model sai_host_model_i (.o_bclk(bclk), .o_frame_sync(frame_sync), .o_serial_audio_input(serial_audio_input));
  serial_audio_input_volume #(.RAMP_CYCLES(2)) serial_audio_input_volume_i (
    .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .i_BCLK(bclk), .i_FRAME_SYNC(frame_sync),
    .i_SERIAL_AUDIO_INPUT(serial_audio_input), .i_ADDR_SLOT(addr_slot), .i_SAMPLE_WIDTH_16(w16),
    .i_PIN_SLOT_SELECT(pin_sel), .i_SLOT_INDEX(slot_index),
    .i_IDLE_POWERDOWN_ENABLE(idle_en), .i_REG_WR(reg_wr), .i_REG_ADDR(reg_addr),
    .i_REG_WDATA(reg_wdata), .o_REG_RDATA(rdata), .o_SAMPLE(smp), .o_SAMPLE_VALID(valid),
    .o_GAIN_CODE(gain), .o_MUTED(muted), .o_HIGHPASS_ENABLE(hpf), .o_LOW_POWER_ENABLE(lpm),
    .o_RATE_RANGE_SELECT(rate), .o_RATE_RANGE_VALID(rate_ok), .o_IDLE_POWERDOWN(idle));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    comparisons++;
    if (got !== want) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    chk({16'h0, got}, {16'h0, want});
  endtask
  task automatic tick;
    @(posedge I_SYS_CLK);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    tick();
    reg_addr = a;
    tick();
    chk8(rdata, want);
  endtask
  // Each presented sample is matched against the oldest note.
  always @(posedge I_SYS_CLK) begin
    if (valid === 1'b1) begin
      chk(smp, (exp_q.size() != 0) ? exp_q.pop_front() : 24'bx);
    end
  end
  // One frame with its settings; the expected sample is noted first.
  task automatic run(input logic [7:0] conv, input logic [7:0] attenuation_code, input logic [7:0] cfg,
                     input logic [3:0] slot, input logic pin, input logic ws16);
    logic [23:0] d, x;
    int w, n;
    d = $random(seed);
    d = {{3{d[20]}}, d[20:1], 1'b0};
    x = ws16 ? {d[23:8], 8'h00} : d;
    x = (attenuation_code == 8'h30) ? x << 1 : (attenuation_code == 8'h50) ? {x[23], x[23:1]} : x;
    x = (conv[6] || attenuation_code == 8'hff) ? 24'h0 : cfg[7] ? -x : x;
    w = cfg[5] ? 64 : (cfg[4:3] == 2'h0) ? 16 : (cfg[4:3] == 2'h1) ? 24 : cfg[3] ? 48 : 32;
    w = cfg[0] ? w * slot : 0;
    pin_sel = pin;
    slot_index = pin ? ~slot : slot;
    addr_slot = pin ? slot : ~slot;
    w16 = ws16;
    wr(sai_pkg::ADDR_CONV, conv);
    wr(sai_pkg::ADDR_VOL, attenuation_code);
    wr(sai_pkg::ADDR_SPORT, cfg);
    exp_q.push_back(x);
    sai_host_model_i.send(cfg, d, w + !cfg[1], ws16 ? 16 : 24, w + 48);
    for (n = 0; exp_q.size() != 0 && n < 100; n++) begin
      tick();
    end
    if (exp_q.size() != 0) begin
      err_count++;
      print_verdict();
    end
  endtask
  // Main sequence.
  initial begin
    int n;
    repeat (12) @(posedge I_SYS_CLK);
    #2;
    I_RESETN = 1'b1;
    rd(sai_pkg::ADDR_CONV, 8'h32);
    rd(sai_pkg::ADDR_VOL, 8'h40);
    rd(sai_pkg::ADDR_SPORT, 8'h11);
    rd(8'h07, 8'h00);
    wr(sai_pkg::ADDR_CONV, 8'h00);
    wr(sai_pkg::ADDR_VOL, 8'h44);
    for (n = 0; gain !== 8'h44 && n < 100; n++) begin
      tick();
    end
    chk8(gain, 8'h44);
    chk8({7'h0, n > 3}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(sai_pkg::ADDR_CONV, 8'(i));
      tick();
      chk8({rate_ok, 4'h0, rate}, {i < 6, 4'h0, 3'(i)});
    end
    run(8'h80, 8'h40, 8'h11, 4'h0, 1'b0, 1'b0);
    run(8'h80, 8'h30, 8'h13, 4'h1, 1'b0, 1'b0);
    run(8'h90, 8'h50, 8'h55, 4'h1, 1'b1, 1'b0);
    run(8'h80, 8'h40, 8'h00, 4'h3, 1'b0, 1'b0);
    run(8'h80, 8'h40, 8'h46, 4'h0, 1'b0, 1'b1);
    run(8'h80, 8'h40, 8'h83, 4'h2, 1'b0, 1'b1);
    run(8'h80, 8'h40, 8'h09, 4'h4, 1'b1, 1'b0);
    run(8'h80, 8'h40, 8'h1b, 4'h1, 1'b0, 1'b0);
    run(8'h80, 8'h40, 8'h23, 4'h1, 1'b0, 1'b0);
    run(8'hc0, 8'h40, 8'h11, 4'h0, 1'b0, 1'b0);
    run(8'h80, 8'hff, 8'h11, 4'h0, 1'b0, 1'b0);
    chk8({7'h0, idle}, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
